// *** rtl/qld_top.sv ***
// top of the quad low-side driver control: link, channels, supply lockout, fault pin
`timescale 1ns/1ps
module qld_top #(
    parameter int CMD_LSB = qld_pkg::CMD_LSB_DEF,
    parameter int FLT_LSB = qld_pkg::FLT_LSB_DEF,
    parameter int SENSE_CYC = qld_pkg::SENSE_CYC,
    parameter int SHUT_CYC = qld_pkg::SHUT_CYC,
    parameter int OL_CYC = qld_pkg::OL_CYC
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic spi_clk,
    input wire logic chip_select_low,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    input wire logic par_in_0,
    input wire logic par_in_1,
    input wire logic par_in_2,
    input wire logic par_in_3,
    input wire logic [qld_pkg::NUM_CH-1:0] over_current,
    input wire logic [qld_pkg::NUM_CH-1:0] open_load,
    input wire logic supply_under,
    input wire logic supply_over,
    output logic drive_out_0,
    output logic drive_out_1,
    output logic drive_out_2,
    output logic drive_out_3,
    output logic fault_pin_out,
    output logic fault_pin_oe
);
    import qld_pkg::*;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_s3;
        logic [NUM_CH-1:0] par_s1;
        logic [NUM_CH-1:0] par_s2;
        logic [NUM_CH-1:0] oc_s1;
        logic [NUM_CH-1:0] oc_s2;
        logic [NUM_CH-1:0] ol_s1;
        logic [NUM_CH-1:0] ol_s2;
        logic uv_s1;
        logic uv_s2;
        logic ov_s1;
        logic ov_s2;
        logic [NUM_CH-1:0] cmd;
        logic [FRAME_BITS-1:0] snap;
        logic [NUM_CH-1:0] drive;
        logic fault_oe;
    } qld_top_reg_t;

    qld_top_reg_t r;
    qld_top_reg_t next_r;

    logic [FRAME_BITS-1:0] rx_word;
    logic [FRAME_CNT_W-1:0] rx_count;
    logic supply_fault;
    logic cs_rise;
    logic cs_fall;
    logic [NUM_CH-1:0] chan_cmd;
    logic [NUM_CH-1:0] chan_fault;
    qld_sense_t sense [NUM_CH];
    qld_chan_stat_t stat [NUM_CH];

    // ---------------------------------------------------------------
    // serial link
    // ---------------------------------------------------------------
    qld_spi_link u_link (
        .spi_clk(spi_clk),
        .chip_select_low(chip_select_low),
        .serial_in(serial_in),
        .snap(r.snap),
        .rx_word(rx_word),
        .rx_count(rx_count),
        .serial_out(serial_out)
    );

    // the pin driver has to follow chip select itself, not a synchronised copy
    assign serial_out_oe = ~chip_select_low; // R6

    // ---------------------------------------------------------------
    // channels
    // ---------------------------------------------------------------
    for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
        qld_channel #(
            .SENSE_CYC(SENSE_CYC),
            .SHUT_CYC(SHUT_CYC),
            .OL_CYC(OL_CYC)
        ) u_chan (
            .core_clk(core_clk),
            .reset_n(reset_n),
            .cmd_on(chan_cmd[g]),
            .supply_fault(supply_fault),
            .sense(sense[g]),
            .stat(stat[g])
        );
    end

    // ---------------------------------------------------------------
    // control
    // ---------------------------------------------------------------
    always_comb begin
        supply_fault = r.uv_s2 | r.ov_s2;
        cs_rise = r.cs_s2 & ~r.cs_s3;
        cs_fall = ~r.cs_s2 & r.cs_s3;
        chan_cmd = r.cmd | r.par_s2; // R19
        for (int i = 0; i < NUM_CH; i++) begin
            sense[i].over_current = r.oc_s2[i];
            sense[i].open_load = r.ol_s2[i];
            chan_fault[i] = stat[i].short_flt | stat[i].open_flt;
        end
    end

    always_comb begin
        next_r = r;
        next_r.cs_s1 = chip_select_low;
        next_r.cs_s2 = r.cs_s1;
        next_r.cs_s3 = r.cs_s2;
        next_r.par_s1 = {par_in_3, par_in_2, par_in_1, par_in_0};
        next_r.par_s2 = r.par_s1;
        next_r.oc_s1 = over_current;
        next_r.oc_s2 = r.oc_s1;
        next_r.ol_s1 = open_load;
        next_r.ol_s2 = r.ol_s1;
        next_r.uv_s1 = supply_under;
        next_r.uv_s2 = r.uv_s1;
        next_r.ov_s1 = supply_over;
        next_r.ov_s2 = r.ov_s1;

        // the link is idle once chip select is high, so its word is steady here
        if (cs_rise && rx_count == FRAME_CNT_W'(FRAME_BITS)) begin // R3
            next_r.cmd = qld_cmd_from_frame(rx_word, CMD_LSB); // R4 R21
        end
        if (supply_fault) begin
            next_r.cmd = CMD_RESET; // R17
        end

        if (cs_fall) begin
            next_r.snap = qld_frame_from_fault(chan_fault, FLT_LSB); // R10 R21
        end

        for (int i = 0; i < NUM_CH; i++) begin
            next_r.drive[i] = stat[i].drive & ~supply_fault; // R16
        end
        next_r.fault_oe = |chan_fault; // R7
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            r <= '0;
            r.cs_s1 <= 1'b1;
            r.cs_s2 <= 1'b1;
            r.cs_s3 <= 1'b1;
            r.cmd <= CMD_RESET; // R17
            r.snap <= SNAP_RESET;
        end else begin
            r <= next_r;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign drive_out_0 = r.drive[0];
    assign drive_out_1 = r.drive[1];
    assign drive_out_2 = r.drive[2];
    assign drive_out_3 = r.drive[3];
    // open drain: only ever pulls low
    assign fault_pin_out = 1'b0;
    assign fault_pin_oe = r.fault_oe; // R7

endmodule : qld_top

// *** rtl/qld_pkg.sv ***
// package: constants, carrier types and bit mapping for the quad low-side driver control
//
// Overview of operation
// R1: a frame starts only on chip select low; clock edges while high are ignored
// R2: serial input is sampled into the shift register on rising serial clock edges
// R3: frames are 8 bits, most significant bit first in both directions
// R4: on/off commands reach the drive latches only on the chip select rising edge
// R5: serial output moves to the next status bit on each falling serial clock edge
// R6: serial output is driven only while chip select is low, else high impedance
// R7: open-drain fault pin is pulled low while any channel shows any fault
// R8: short to supply checked while on; open load/short to ground while off
// R9: fault bits follow the fault condition and clear by themselves
// R10: chip select falling edge snapshots fault bits; the frame returns that snapshot
// R11: overcurrent sends a channel into low-duty retry for as long as it persists
// R12: overcurrent must persist one sense interval; that is also the retry on-time
// R13: confirmed overcurrent switches the channel off for the shutdown interval
// R14: retry on/off timing gives the nominal 1.56 percent duty, within 1.4 to 1.7
// R15: open load is reported only after persisting 12.5 to 100 us
// R16: supply over- or undervoltage forces all outputs off while active
// R17: reset and supply faults clear the command latches, not merely mask them
// R18: master keeps the serial clock at or below 4.0 MHz
// R19: each output is on when its serial command or its parallel input is high
// R20: master waits at least 1.0 us between chip select rising and next falling
// R21: frame bit positions of commands and fault bits are parameters
// R22: sense, shutdown and open-load intervals are per-channel timebase counters
package qld_pkg;

    localparam int NUM_CH = 4;
    localparam int FRAME_BITS = 8;
    localparam int FRAME_CNT_W = 4;
    localparam int TMR_W = 20;

    // default frame layout: commands and fault bits both in the low nibble
    localparam int CMD_LSB_DEF = 0;
    localparam int FLT_LSB_DEF = 0;

    localparam real CLK_PERIOD_NS = 10.0;
    localparam real T_SENSE_US = 62.5;
    localparam real T_SHUT_MS = 3.94;
    localparam real T_OL_US = 50.0;
    localparam real T_GAP_US = 1.0;
    localparam real F_SCLK_MAX_MHZ = 4.0;

    // nominal figures divide evenly into the clock period
    localparam int SENSE_CYC = int'(T_SENSE_US * 1000.0 / CLK_PERIOD_NS);
    localparam int SHUT_CYC = int'(T_SHUT_MS * 1000000.0 / CLK_PERIOD_NS);
    localparam int OL_CYC = int'(T_OL_US * 1000.0 / CLK_PERIOD_NS);
    localparam int GAP_CYC = int'(T_GAP_US * 1000.0 / CLK_PERIOD_NS);

    localparam logic [3:0] CMD_RESET = 4'h0;
    localparam logic [7:0] SNAP_RESET = 8'h00;

    typedef enum logic [1:0] {
        QLD_NORMAL,
        QLD_SENSE,
        QLD_SHUT,
        QLD_RETRY
    } qld_chan_state_t;

    typedef struct packed {
        logic over_current;
        logic open_load;
    } qld_sense_t;

    typedef struct packed {
        logic drive;
        logic short_flt;
        logic open_flt;
    } qld_chan_stat_t;

    function automatic logic [NUM_CH-1:0] qld_cmd_from_frame(
        input logic [FRAME_BITS-1:0] frame,
        input int lsb
    );
        logic [NUM_CH-1:0] c;
        c = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            c[i] = frame[lsb + i];
        end
        return c;
    endfunction : qld_cmd_from_frame

    function automatic logic [FRAME_BITS-1:0] qld_frame_from_fault(
        input logic [NUM_CH-1:0] flt,
        input int lsb
    );
        logic [FRAME_BITS-1:0] f;
        f = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            f[lsb + i] = flt[i];
        end
        return f;
    endfunction : qld_frame_from_fault

endpackage : qld_pkg

// *** rtl/qld_spi_link.sv ***
// serial-clock side of the command/status link
`timescale 1ns/1ps
module qld_spi_link (
    input wire logic spi_clk,
    input wire logic chip_select_low,
    input wire logic serial_in,
    input wire logic [qld_pkg::FRAME_BITS-1:0] snap,
    output logic [qld_pkg::FRAME_BITS-1:0] rx_word,
    output logic [qld_pkg::FRAME_CNT_W-1:0] rx_count,
    output logic serial_out
);
    import qld_pkg::*;

    logic fresh;
    logic [2:0] tx_idx;

    // ---------------------------------------------------------------
    // receive
    // ---------------------------------------------------------------
    // fresh marks the first rising edge of a frame; set while deselected
    always_ff @(posedge spi_clk or posedge chip_select_low) begin
        if (chip_select_low) begin
            fresh <= 1'b1; // R1
        end else begin
            fresh <= 1'b0;
        end
    end

    // the word and count stay frozen after the frame; the core reads them then
    always_ff @(posedge spi_clk) begin
        if (!chip_select_low) begin // R1
            rx_word <= {rx_word[FRAME_BITS-2:0], serial_in}; // R2 R3
            if (fresh) begin
                rx_count <= 4'h1;
            end else if (rx_count != 4'hf) begin
                rx_count <= rx_count + 4'h1;
            end
        end
    end

    // ---------------------------------------------------------------
    // transmit
    // ---------------------------------------------------------------
    // assumes the clock idles low, so the first falling edge follows bit 7
    always_ff @(negedge spi_clk or posedge chip_select_low) begin
        if (chip_select_low) begin
            tx_idx <= 3'h0;
        end else if (tx_idx != 3'h7) begin
            tx_idx <= tx_idx + 3'h1; // R5
        end
    end

    // snap is held steady by the core for the whole frame
    assign serial_out = snap[3'h7 - tx_idx]; // R3 R10

endmodule : qld_spi_link

// *** rtl/qld_channel.sv ***
// one output channel: overcurrent retry timing and open-load qualification
`timescale 1ns/1ps
module qld_channel #(
    parameter int SENSE_CYC = qld_pkg::SENSE_CYC,
    parameter int SHUT_CYC = qld_pkg::SHUT_CYC,
    parameter int OL_CYC = qld_pkg::OL_CYC
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic cmd_on,
    input wire logic supply_fault,
    input wire qld_pkg::qld_sense_t sense,
    output qld_pkg::qld_chan_stat_t stat
);
    import qld_pkg::*;

    typedef struct packed {
        qld_chan_state_t mode;
        logic [TMR_W-1:0] tmr;
        logic [TMR_W-1:0] ol_tmr;
        logic open_flt;
    } qld_chan_reg_t;

    localparam logic [TMR_W-1:0] SENSE_LAST = TMR_W'(SENSE_CYC - 1);
    localparam logic [TMR_W-1:0] SHUT_LAST = TMR_W'(SHUT_CYC - 1);
    localparam logic [TMR_W-1:0] OL_LAST = TMR_W'(OL_CYC - 1);

    qld_chan_reg_t r;
    qld_chan_reg_t next_r;

    always_comb begin
        next_r = r;
        next_r.tmr = r.tmr + 1'b1;
        case (r.mode)
            QLD_NORMAL: begin
                next_r.tmr = '0;
                if (cmd_on && sense.over_current) begin // R8
                    next_r.mode = QLD_SENSE;
                    next_r.tmr = TMR_W'(1);
                end
            end
            QLD_SENSE: begin
                if (!cmd_on || !sense.over_current) begin
                    next_r.mode = QLD_NORMAL;
                end else if (r.tmr == SENSE_LAST) begin // R12
                    next_r.mode = QLD_SHUT;
                    next_r.tmr = '0;
                end
            end
            QLD_SHUT: begin
                if (!cmd_on) begin
                    next_r.mode = QLD_NORMAL;
                end else if (r.tmr == SHUT_LAST) begin // R13
                    next_r.mode = QLD_RETRY;
                    next_r.tmr = '0;
                end
            end
            QLD_RETRY: begin
                // stays in the low-duty loop until a retry on-phase no longer sees the fault
                if (!cmd_on || !sense.over_current) begin // R11
                    next_r.mode = QLD_NORMAL;
                end else if (r.tmr == SENSE_LAST) begin // R12 R14
                    next_r.mode = QLD_SHUT;
                    next_r.tmr = '0;
                end
            end
            default: begin
                next_r.mode = QLD_NORMAL;
            end
        endcase
        if (supply_fault) begin
            next_r.mode = QLD_NORMAL;
            next_r.tmr = '0;
        end

        // open load is judged only while the channel is commanded off
        if (!cmd_on && sense.open_load) begin // R8 R15
            if (r.ol_tmr == OL_LAST) begin
                next_r.open_flt = 1'b1;
            end else begin
                next_r.ol_tmr = r.ol_tmr + 1'b1;
            end
        end else begin
            next_r.ol_tmr = '0;
            next_r.open_flt = 1'b0; // R9
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            r <= '{mode: QLD_NORMAL, tmr: '0, ol_tmr: '0, open_flt: 1'b0};
        end else begin
            r <= next_r; // R22
        end
    end

    assign stat.drive = cmd_on && !supply_fault && (r.mode != QLD_SHUT);
    assign stat.short_flt = (r.mode == QLD_SHUT) || (r.mode == QLD_RETRY); // R9
    assign stat.open_flt = r.open_flt;

endmodule : qld_channel

// *** verif/qld_top_asserts.sv ***
// assertion checker for the quad low-side driver control top
`timescale 1ns/1ps
module qld_top_asserts #(
    parameter int SENSE_CYC = qld_pkg::SENSE_CYC,
    parameter int SHUT_CYC = qld_pkg::SHUT_CYC
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic chip_select_low,
    input wire logic serial_out_oe,
    input wire logic par_in_0,
    input wire logic par_in_1,
    input wire logic par_in_2,
    input wire logic par_in_3,
    input wire logic [qld_pkg::NUM_CH-1:0] over_current,
    input wire logic [qld_pkg::NUM_CH-1:0] open_load,
    input wire logic supply_under,
    input wire logic supply_over,
    input wire logic drive_out_0,
    input wire logic drive_out_1,
    input wire logic drive_out_2,
    input wire logic drive_out_3,
    input wire logic fault_pin_out,
    input wire logic fault_pin_oe
);
    import qld_pkg::*;
    wire logic [3:0] par = {par_in_3, par_in_2, par_in_1, par_in_0};
    wire logic [3:0] drv = {drive_out_3, drive_out_2, drive_out_1, drive_out_0};
    wire logic sup = supply_under | supply_over;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // a channel caught in shutdown keeps its fault to the end of its off period, then drops it after one retry cycle
    localparam logic [21:0] QUIET = 22'(SHUT_CYC + SENSE_CYC + 6);
    logic [21:0] quiet_cnt;
    always_ff @(posedge core_clk) begin
        if (!reset_n || over_current != 4'h0 || open_load != 4'h0) begin
            quiet_cnt <= 22'h0;
        end else if (quiet_cnt != QUIET) begin
            quiet_cnt <= quiet_cnt + 22'h1;
        end
    end
    // ----
    // windows allow for the two-flop input synchronisers
    // ----
    property p_oe_cs; serial_out_oe == !chip_select_low; endproperty
    a_oe_cs: assert property (p_oe_cs) else $error("serial out enable wrong");
    property p_od_data; fault_pin_out == 1'b0; endproperty
    a_od_data: assert property (p_od_data) else $error("fault pin data not low");
    property p_supply_off; sup [*4] |-> drv == 4'h0; endproperty
    a_supply_off: assert property (p_supply_off) else $error("drive during supply fault");
    property p_latch_clear; sup [*4] ##1 (!sup && par == 4'h0) [*8] |-> drv == 4'h0; endproperty
    a_latch_clear: assert property (p_latch_clear) else $error("command survived supply");
    property p_hold_sel;
        (!chip_select_low && par == 4'h0 && quiet_cnt == QUIET && !sup) [*6] |-> $stable(drv);
    endproperty
    a_hold_sel: assert property (p_hold_sel) else $error("drive moved while selected");
    property p_par_on;
        (par == 4'hf && quiet_cnt == QUIET && !sup) [*6] |-> drv == 4'hf;
    endproperty
    a_par_on: assert property (p_par_on) else $error("parallel input ignored");
    property p_pin_release; quiet_cnt == QUIET |-> !fault_pin_oe; endproperty
    a_pin_release: assert property (p_pin_release) else $error("fault pin stuck");
    property p_ol_wait;
        open_load != 4'h0 && $past(open_load) == 4'h0 && over_current == 4'h0 && !fault_pin_oe
            |=> !fault_pin_oe [*4];
    endproperty
    a_ol_wait: assert property (p_ol_wait) else $error("open load reported early");
    property p_shut_hold; $fell(drive_out_0) && over_current[0] && par_in_0 |=> !drive_out_0 [*8];
    endproperty
    a_shut_hold: assert property (p_shut_hold) else $error("retry too early");
    c_frame: cover property (!chip_select_low [*8]);
    c_fault: cover property ($rose(fault_pin_oe));
    c_retry: cover property ($fell(drive_out_0) && over_current[0]);
endmodule : qld_top_asserts
bind qld_top qld_top_asserts #(
    .SENSE_CYC(SENSE_CYC),
    .SHUT_CYC(SHUT_CYC)
) u_chk (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .chip_select_low(chip_select_low),
    .serial_out_oe(serial_out_oe),
    .par_in_0(par_in_0),
    .par_in_1(par_in_1),
    .par_in_2(par_in_2),
    .par_in_3(par_in_3),
    .over_current(over_current),
    .open_load(open_load),
    .supply_under(supply_under),
    .supply_over(supply_over),
    .drive_out_0(drive_out_0),
    .drive_out_1(drive_out_1),
    .drive_out_2(drive_out_2),
    .drive_out_3(drive_out_3),
    .fault_pin_out(fault_pin_out),
    .fault_pin_oe(fault_pin_oe)
);

// *** verif/qld_spi_master.sv ***
// spi master model: sends command frames and collects status bits
`timescale 1ns/1ps
module qld_spi_master (
    output logic spi_clk,
    output logic chip_select_low,
    output logic serial_in,
    input wire logic serial_out
);
    localparam time T_HALF = 125ns;
    initial begin
        spi_clk = 1'b0;
        chip_select_low = 1'b1;
        serial_in = 1'b0;
    end
    // clock stands low between frames; data falls to its pull-down level
    task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        // keeps every link edge off the core clock edges
        #3ns;
        chip_select_low = 1'b0;
        #100ns;
        for (int i = nbits - 1; i >= 0; i--) begin
            serial_in = tx[i];
            #T_HALF spi_clk = 1'b1;
            rx = {rx[6:0], serial_out};
            #T_HALF spi_clk = 1'b0;
        end
        #100ns chip_select_low = 1'b1;
        serial_in = 1'b0;
        #1000ns;
    endtask : xfer
endmodule : qld_spi_master

// *** verif/qld_top_tb.sv ***
// self-checking bench for the quad low-side driver control top
`timescale 1ns/1ps
module qld_top_tb;
    import qld_pkg::*;
    localparam int SENSE = 8;
    localparam int SHUT = 40;
    localparam int OLC = 6;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    wire spi_clk, chip_select_low, serial_in;
    logic serial_out, serial_out_oe, fault_pin_out, fault_pin_oe;
    logic [3:0] par = 4'h0;
    logic [3:0] oc = 4'h0;
    logic [3:0] ol = 4'h0;
    logic sup_u = 1'b0;
    logic sup_o = 1'b0;
    wire [3:0] drv;
    logic [7:0] rx;
    int n_fail = 0;
    int checks = 0;
    int seed = 32'h3d9b;
    // a released status line shows the inverse of serial_out, never a plain copy of it
    wire so_line = serial_out_oe ? serial_out : ~serial_out;
    wire fault_line_n = fault_pin_oe ? fault_pin_out : 1'b1;
    initial forever #5 core_clk = ~core_clk;
    initial begin
        #500us;
        n_fail++;
        tally_and_finish();
    end
    qld_spi_master m (.spi_clk(spi_clk), .chip_select_low(chip_select_low),
        .serial_in(serial_in), .serial_out(so_line));
    qld_top #(.SENSE_CYC(SENSE), .SHUT_CYC(SHUT), .OL_CYC(OLC)) uut (
        .core_clk(core_clk), .reset_n(reset_n), .spi_clk(spi_clk),
        .chip_select_low(chip_select_low), .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .par_in_0(par[0]), .par_in_1(par[1]),
        .par_in_2(par[2]), .par_in_3(par[3]), .over_current(oc), .open_load(ol),
        .supply_under(sup_u), .supply_over(sup_o), .drive_out_0(drv[0]),
        .drive_out_1(drv[1]), .drive_out_2(drv[2]), .drive_out_3(drv[3]),
        .fault_pin_out(fault_pin_out), .fault_pin_oe(fault_pin_oe));
    // ----
    // helpers
    // ----
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc
    function automatic logic [3:0] exp_drv(input logic [3:0] cmd, input logic [3:0] p,
        input logic s);
        return s ? 4'h0 : (cmd | p);
    endfunction : exp_drv
    task automatic wait_drv0(input logic lvl, output int n);
        n = 0;
        while (drv[0] !== lvl && n < 1000) begin
            cyc(1);
            n++;
        end
        if (n >= 1000) begin
            n_fail++;
            tally_and_finish();
        end
    endtask : wait_drv0
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    // ----
    // scenarios
    // ----
    initial begin
        logic [7:0] cmd;
        logic [3:0] mask;
        int n;
        @(posedge core_clk);
        @(posedge core_clk) reset_n <= 1'b1;
        cyc(4);
        for (int i = 0; i < 8; i++) begin
            cmd = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
            @(posedge core_clk) par <= (i < 2) ? 4'h0 : (i == 2) ? 4'hf : 4'($random(seed));
            m.xfer(cmd, 8, rx);
            cyc(6);
            check({4'h0, drv}, {4'h0, exp_drv(cmd[3:0], par, 1'b0)});
        end
        m.xfer(~cmd, 7, rx);
        cyc(6);
        check({4'h0, drv}, {4'h0, exp_drv(cmd[3:0], par, 1'b0)});
        $display("test commands done");
        @(posedge core_clk) par <= 4'h0;
        m.xfer(8'h00, 8, rx);
        for (int i = 0; i < 4; i++) begin
            mask = (i == 0) ? 4'hf : 4'($random(seed));
            @(posedge core_clk) ol <= mask;
            cyc(OLC + 8);
            m.xfer(8'h00, 8, rx);
            check(rx, {4'h0, mask});
            check({7'h0, fault_line_n}, {7'h0, mask == 4'h0});
            @(posedge core_clk) ol <= 4'h0;
            cyc(8);
            check({7'h0, fault_line_n}, 8'h01);
        end
        m.xfer(8'h0f, 8, rx);
        @(posedge core_clk) ol <= 4'hf;
        cyc(OLC + 20);
        m.xfer(8'h0f, 8, rx);
        check(rx, 8'h00);
        @(posedge core_clk) ol <= 4'h0;
        $display("test status done");
        m.xfer(8'h00, 8, rx);
        @(posedge core_clk) par <= 4'h1;
        cyc(5);
        @(posedge core_clk) oc <= 4'h1;
        wait_drv0(1'b0, n);
        check(8'(n), 8'(SENSE + 3));
        for (int k = 0; k < 2; k++) begin
            wait_drv0(1'b1, n);
            check(8'(n), 8'(SHUT));
            wait_drv0(1'b0, n);
            check(8'(n), 8'(SENSE));
        end
        m.xfer(8'h00, 8, rx);
        check(rx, 8'h01);
        @(posedge core_clk) oc <= 4'h0;
        // a shutdown already under way runs to its end before the fault can clear
        cyc(SHUT + SENSE + 8);
        check({6'h0, drv[0], fault_line_n}, 8'h03);
        $display("test retry done");
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk) par <= 4'h0;
            m.xfer(8'h0f, 8, rx);
            @(posedge core_clk) {sup_o, sup_u} <= k ? 2'b10 : 2'b01;
            par <= k ? 4'h2 : 4'h0;
            cyc(5);
            check({4'h0, drv}, 8'h00);
            @(posedge core_clk) {sup_o, sup_u} <= 2'b00;
            cyc(12);
            check({4'h0, drv}, {4'h0, exp_drv(4'h0, par, 1'b0)});
        end
        $display("test supply done");
        tally_and_finish();
    end
endmodule : qld_top_tb
